// ### i2ctc_params.svh
// constants for the i2c timing configuration block
//---------------------------------------------------------------------
// Summary of operation
// R1: sda input held internally, field times 50 ns
// R2: filter rejects glitches up to depth times 10ns
// R3: master scl high lasts high count units counted once filtered scl reads high
// R4: master scl low lasts low count units
// R5: slave shows sda low count before releasing
// R6: reset widths meet standard mode at 26 MHz
// R7: clock source field picks oscillator frequency
// R8: selection applies in oscillator mode or missing clock
// R9: counters reload from fields on entering each master low, master high or slave setup phase
//---------------------------------------------------------------------
`ifndef I2CTC_PARAMS_SVH
`define I2CTC_PARAMS_SVH

// register offsets
`define I2CTC_ADDR_FILTER_HOLD  8'h10
`define I2CTC_ADDR_SCL_HIGH     8'h11
`define I2CTC_ADDR_SCL_LOW      8'h12
`define I2CTC_ADDR_SPARE        8'h13
`define I2CTC_ADDR_CLOCK_SELECT 8'h14

// field positions
`define I2CTC_HOLD_MSB          6
`define I2CTC_HOLD_LSB          4
`define I2CTC_DEPTH_MSB         3
`define I2CTC_DEPTH_LSB         0
`define I2CTC_CLKSRC_MSB        2
`define I2CTC_CLKSRC_LSB        1
`define I2CTC_CLKSEL_RW_MASK    8'h1f

// reset values
`define I2CTC_RST_FILTER_HOLD   8'h17
`define I2CTC_RST_SCL_HIGH      8'h82
`define I2CTC_RST_SCL_LOW       8'h82
`define I2CTC_RST_SPARE         8'h00
`define I2CTC_RST_CLOCK_SELECT  8'h00

// timing: units in ns, clock period in ns
`define I2CTC_CLOCK_PERIOD_NS   100
`define I2CTC_HOLD_UNIT_NS      50
`define I2CTC_DEPTH_UNIT_NS     10
`define I2CTC_SCL_UNIT_NS       50
// worst oscillator rate and standard-mode minima for the reset widths
`define I2CTC_FAST_OSC_MHZ      26
`define I2CTC_MIN_HIGH_NS       4000
`define I2CTC_MIN_LOW_NS        4700

`endif

// ### i2ctc_pkg.sv
// types of the i2c timing configuration block
package i2ctc_pkg;

	typedef struct packed {
		logic [7:0] filterHold;
		logic [7:0] sclHigh;
		logic [7:0] sclLow;
		logic [7:0] spare;
		logic [7:0] clockSelect;
	} i2ctc_regs_t;

	typedef enum logic [2:0] {
		IDLE,
		MASTER_LOW,
		MASTER_HIGH,
		SLAVE_STRETCH,
		SLAVE_SETUP
	} i2ctc_phase_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} i2ctc_bus_t;

	typedef struct packed {
		logic       slaveStretch;
		logic       slaveDataValid;
		logic       slaveSdaBit;
	} i2ctc_slave_req_t;

endpackage

// ### i2ctc_filter.sv
// change filter: output follows input once it differs for limit+1 cycles
`timescale 1ns/1ps
module i2ctc_filter #(
	parameter logic RESET_LEVEL = 1'b1
) (
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       din,
	input  wire logic [7:0] limit,
	output logic            dout
);

	typedef struct packed {
		logic [7:0] count;
		logic       level;
	} i2ctc_filt_state_t;

	i2ctc_filt_state_t state;
	i2ctc_filt_state_t next_state;

	always_comb begin
		next_state = state;
		if (din == state.level) begin
			next_state.count = 8'h00; // R2
		end else if (state.count >= limit) begin
			next_state.level = din;
			next_state.count = 8'h00;
		end else begin
			next_state.count = state.count + 8'h01;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state <= '{count: 8'h00, level: RESET_LEVEL};
		end else begin
			state <= next_state;
		end
	end

	assign dout = state.level;

	a_filter_no_early: assert property (@(posedge clock) disable iff (reset) // R2
		(dout != $past(dout)) |-> $past(din != dout, 1) && ($past(state.count) >= $past(limit)))
		else $error("filter output moved before its limit");

endmodule // i2ctc_filter

// ### i2c_timing_config.sv
// i2c timing configuration: registers, filters, hold and scl generator
`timescale 1ns/1ps
`include "i2ctc_params.svh"
module i2c_timing_config (
	input  wire logic                     clock,
	input  wire logic                     reset,
	input  wire i2ctc_pkg::i2ctc_bus_t    bus,
	output logic [7:0]                    rdata,
	input  wire logic                     sclIn,
	input  wire logic                     sdaIn,
	output logic                          sclOut,
	output logic                          sclOe,
	output logic                          sdaOut,
	output logic                          sdaOe,
	output logic                          sclFiltered,
	output logic                          sdaFiltered,
	input  wire logic                     masterRun,
	input  wire i2ctc_pkg::i2ctc_slave_req_t slaveReq,
	output logic                          slaveReleased,
	input  wire logic                     internalOscillatorMode,
	input  wire logic                     pixelClockPresent,
	output logic [1:0]                    internalOscillatorSelect,
	output logic                          internalOscillatorActive,
	output logic [7:0]                    spareControlBits
);

	//-----------------------------------------------------------------
	// time to cycles
	//-----------------------------------------------------------------
	// rounds up, never below one cycle: these are least widths
	function automatic logic [7:0] toCycles(input logic [7:0] units, input int unitNs);
		logic [15:0] ns;
		logic [15:0] cyc;
		ns  = 16'(units) * 16'(unitNs);
		cyc = (ns + 16'(`I2CTC_CLOCK_PERIOD_NS - 1)) / 16'(`I2CTC_CLOCK_PERIOD_NS);
		toCycles = (cyc == 16'h0000) ? 8'h01 : cyc[7:0];
	endfunction

	// R6: 0x82 units at the fast oscillator still exceed the minima
	localparam int FastHighNs = (`I2CTC_RST_SCL_HIGH * 1000) / `I2CTC_FAST_OSC_MHZ;
	localparam int FastLowNs  = (`I2CTC_RST_SCL_LOW * 1000) / `I2CTC_FAST_OSC_MHZ;
	localparam logic WidthsOk = (FastHighNs >= `I2CTC_MIN_HIGH_NS)
		&& (FastLowNs >= `I2CTC_MIN_LOW_NS);

	//-----------------------------------------------------------------
	// state
	//-----------------------------------------------------------------
	typedef struct packed {
		i2ctc_pkg::i2ctc_regs_t  regs;
		logic [7:0]              rdata;
		logic [1:0]              sclSync;
		logic [1:0]              sdaSync;
		logic [1:0]              modeSync;
		logic [1:0]              presentSync;
		i2ctc_pkg::i2ctc_phase_t phase;
		logic [7:0]              count;
		logic                    sclOe;
		logic                    sdaOe;
		logic                    sdaBit;
		logic                    released;
		logic [1:0]              oscSelect;
		logic                    oscActive;
		logic                    sclFilt;
		logic                    sdaFilt;
	} i2ctc_top_state_t;

	i2ctc_top_state_t state;
	i2ctc_top_state_t next_state;

	logic       sclClean;
	logic       sdaClean;
	logic       sdaHeld;
	logic [7:0] depthCycles;
	logic [7:0] holdCycles;
	logic [7:0] highCycles;
	logic [7:0] lowCycles;

	assign depthCycles = toCycles(8'(state.regs.filterHold[`I2CTC_DEPTH_MSB:`I2CTC_DEPTH_LSB]),
		`I2CTC_DEPTH_UNIT_NS); // R2
	assign holdCycles  = toCycles(8'(state.regs.filterHold[`I2CTC_HOLD_MSB:`I2CTC_HOLD_LSB]),
		`I2CTC_HOLD_UNIT_NS); // R1
	assign highCycles  = toCycles(state.regs.sclHigh, `I2CTC_SCL_UNIT_NS); // R3
	assign lowCycles   = toCycles(state.regs.sclLow, `I2CTC_SCL_UNIT_NS); // R4

	//-----------------------------------------------------------------
	// glitch filters and sda hold
	//-----------------------------------------------------------------
	i2ctc_filter #(.RESET_LEVEL(1'b1)) sclFilter (
		.clock (clock),
		.reset (reset),
		.din   (state.sclSync[1]),
		.limit (depthCycles),
		.dout  (sclClean)
	);

	i2ctc_filter #(.RESET_LEVEL(1'b1)) sdaFilter (
		.clock (clock),
		.reset (reset),
		.din   (state.sdaSync[1]),
		.limit (depthCycles),
		.dout  (sdaClean)
	);

	// hold delays sda so a change near scl falling is not misread
	i2ctc_filter #(.RESET_LEVEL(1'b1)) sdaHoldStage (
		.clock (clock),
		.reset (reset),
		.din   (sdaClean),
		.limit (holdCycles),
		.dout  (sdaHeld)
	);

	//-----------------------------------------------------------------
	// next state
	//-----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_state.sclSync     = {state.sclSync[0], sclIn};
		next_state.sdaSync     = {state.sdaSync[0], sdaIn};
		next_state.modeSync    = {state.modeSync[0], internalOscillatorMode};
		next_state.presentSync = {state.presentSync[0], pixelClockPresent};
		next_state.sclFilt     = sclClean;
		next_state.sdaFilt     = sdaHeld;
		next_state.released    = 1'b0;
		next_state.rdata       = 8'h00;

		// register writes
		if (bus.wr) begin
			unique case (bus.addr)
				`I2CTC_ADDR_FILTER_HOLD:  next_state.regs.filterHold = bus.wdata;
				`I2CTC_ADDR_SCL_HIGH:     next_state.regs.sclHigh = bus.wdata;
				`I2CTC_ADDR_SCL_LOW:      next_state.regs.sclLow = bus.wdata;
				`I2CTC_ADDR_SPARE:        next_state.regs.spare = bus.wdata;
				`I2CTC_ADDR_CLOCK_SELECT: begin
					next_state.regs.clockSelect = bus.wdata & `I2CTC_CLKSEL_RW_MASK;
				end
				default: ;
			endcase
		end

		// register reads, unmapped reads answer zero
		if (bus.rd) begin
			unique case (bus.addr)
				`I2CTC_ADDR_FILTER_HOLD:  next_state.rdata = state.regs.filterHold;
				`I2CTC_ADDR_SCL_HIGH:     next_state.rdata = state.regs.sclHigh;
				`I2CTC_ADDR_SCL_LOW:      next_state.rdata = state.regs.sclLow;
				`I2CTC_ADDR_SPARE:        next_state.rdata = state.regs.spare;
				`I2CTC_ADDR_CLOCK_SELECT: next_state.rdata = state.regs.clockSelect;
				default:                  next_state.rdata = 8'h00;
			endcase
		end

		// oscillator frequency choice
		next_state.oscActive = state.modeSync[1] || !state.presentSync[1]; // R8
		next_state.oscSelect = state.regs.clockSelect[`I2CTC_CLKSRC_MSB:`I2CTC_CLKSRC_LSB]; // R7

		// scl phase machine
		unique case (state.phase)
			i2ctc_pkg::IDLE: begin
				next_state.sclOe = 1'b0;
				if (masterRun) begin
					next_state.phase = i2ctc_pkg::MASTER_LOW;
					next_state.count = lowCycles; // R9
					next_state.sclOe = 1'b1;
					next_state.sdaOe = 1'b0;
				end else if (slaveReq.slaveStretch) begin
					next_state.phase = i2ctc_pkg::SLAVE_STRETCH;
					next_state.sclOe = 1'b1;
				end else begin
					next_state.sdaOe = 1'b0;
				end
			end
			i2ctc_pkg::MASTER_LOW: begin
				if (state.count <= 8'h01) begin
					next_state.phase = i2ctc_pkg::MASTER_HIGH;
					next_state.count = highCycles; // R9
					next_state.sclOe = 1'b0;
				end else begin
					next_state.count = state.count - 8'h01; // R4
				end
			end
			i2ctc_pkg::MASTER_HIGH: begin
				// a slave stretching scl holds the high count
				if (state.sclFilt) begin
					if (state.count <= 8'h01) begin
						if (masterRun) begin
							next_state.phase = i2ctc_pkg::MASTER_LOW;
							next_state.count = lowCycles; // R9
							next_state.sclOe = 1'b1;
						end else begin
							next_state.phase = i2ctc_pkg::IDLE;
						end
					end else begin
						next_state.count = state.count - 8'h01; // R3
					end
				end
			end
			i2ctc_pkg::SLAVE_STRETCH: begin
				if (slaveReq.slaveDataValid) begin
					next_state.phase  = i2ctc_pkg::SLAVE_SETUP;
					next_state.count  = lowCycles; // R5
					next_state.sdaBit = slaveReq.slaveSdaBit;
					next_state.sdaOe  = !slaveReq.slaveSdaBit;
				end else if (!slaveReq.slaveStretch) begin
					next_state.phase = i2ctc_pkg::IDLE;
					next_state.sclOe = 1'b0;
				end
			end
			i2ctc_pkg::SLAVE_SETUP: begin
				if (state.count <= 8'h01) begin
					next_state.phase    = i2ctc_pkg::IDLE;
					next_state.sclOe    = 1'b0; // R5
					next_state.released = 1'b1;
				end else begin
					next_state.count = state.count - 8'h01;
				end
			end
			default: begin
				next_state.phase = i2ctc_pkg::IDLE;
				next_state.sclOe = 1'b0;
			end
		endcase
	end

	//-----------------------------------------------------------------
	// registers
	//-----------------------------------------------------------------
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state <= '0;
			state.regs <= '{filterHold:  `I2CTC_RST_FILTER_HOLD, // R1
				sclHigh:     `I2CTC_RST_SCL_HIGH, // R6
				sclLow:      `I2CTC_RST_SCL_LOW,
				spare:       `I2CTC_RST_SPARE,
				clockSelect: `I2CTC_RST_CLOCK_SELECT}; // R7
			state.sclSync     <= 2'h3;
			state.sdaSync     <= 2'h3;
			state.presentSync <= 2'h0;
			state.sclFilt     <= 1'b1;
			state.sdaFilt     <= 1'b1;
			state.oscActive   <= 1'b1;
			state.phase       <= i2ctc_pkg::IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign rdata                    = state.rdata;
	assign sclOut                   = 1'b0 & state.sclOe;
	assign sclOe                    = state.sclOe;
	assign sdaOut                   = state.sdaBit & 1'b0;
	assign sdaOe                    = state.sdaOe;
	assign sclFiltered              = state.sclFilt;
	assign sdaFiltered              = state.sdaFilt;
	assign slaveReleased            = state.released;
	assign internalOscillatorSelect = state.oscSelect;
	assign internalOscillatorActive = state.oscActive;
	assign spareControlBits         = state.regs.spare;

	//-----------------------------------------------------------------
	// checks
	//-----------------------------------------------------------------
	a_reset_widths_ok: assert property (@(posedge clock) disable iff (reset) // R6
		WidthsOk)
		else $error("reset scl widths too short at fast oscillator");

	a_low_phase_len: assert property (@(posedge clock) disable iff (reset) // R4
		($rose(state.phase == i2ctc_pkg::MASTER_LOW) && state.count == 8'h06)
		|-> sclOe [*6] ##1 (state.phase == i2ctc_pkg::MASTER_HIGH))
		else $error("master scl low width wrong");

	a_high_reload: assert property (@(posedge clock) disable iff (reset) // R9
		(state.phase == i2ctc_pkg::MASTER_LOW && next_state.phase == i2ctc_pkg::MASTER_HIGH)
		|=> state.count == $past(highCycles))
		else $error("high count not reloaded");

	a_high_count_down: assert property (@(posedge clock) disable iff (reset) // R3
		(state.phase == i2ctc_pkg::MASTER_HIGH && state.sclFilt && state.count > 8'h01)
		|=> state.phase == i2ctc_pkg::MASTER_HIGH && state.count == $past(state.count) - 8'h01)
		else $error("master high count not advancing");

	a_setup_release: assert property (@(posedge clock) disable iff (reset) // R5
		(state.phase == i2ctc_pkg::SLAVE_STRETCH && slaveReq.slaveDataValid)
		|=> state.count == $past(lowCycles) && sclOe && sdaOe == !$past(slaveReq.slaveSdaBit))
		else $error("slave setup not started with low count");

	a_release_pulse: assert property (@(posedge clock) disable iff (reset) // R5
		slaveReleased |-> !sclOe && $past(state.phase == i2ctc_pkg::SLAVE_SETUP))
		else $error("slave release without setup");

	a_hold_cycles: assert property (@(posedge clock) disable iff (reset) // R1
		holdCycles == ((state.regs.filterHold[`I2CTC_HOLD_MSB:`I2CTC_HOLD_LSB] == 3'h0) ? 8'h01
			: 8'(({1'b0, state.regs.filterHold[`I2CTC_HOLD_MSB:`I2CTC_HOLD_LSB]} + 4'h1) >> 1)))
		else $error("hold cycles mismatch");

	a_osc_select: assert property (@(posedge clock) disable iff (reset) // R7
		$changed(state.regs.clockSelect[2:1]) |=> ##1 internalOscillatorSelect
			== $past(state.regs.clockSelect[2:1], 2))
		else $error("oscillator select did not follow field");

	a_osc_missing: assert property (@(posedge clock) disable iff (reset) // R8
		(!pixelClockPresent [*4]) |-> internalOscillatorActive)
		else $error("oscillator not used with clock missing");

	a_read_answer: assert property (@(posedge clock) disable iff (reset)
		(bus.rd && !bus.wr && bus.addr == `I2CTC_ADDR_SCL_LOW) |=> rdata == $past(state.regs.sclLow))
		else $error("read data wrong");

endmodule // i2c_timing_config

// ### i2ctc_bus_model.sv
// local bus partner: pull-ups and a slave that can stretch scl
`timescale 1ns/1ps
module i2ctc_bus_model (
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       sclOe,
	input  wire logic       sdaOe,
	input  wire logic [7:0] stretchCycles,
	input  wire logic       pullSdaLow,
	output logic            sclWire,
	output logic            sdaWire
);
	logic [7:0] stretchLeft;

	// loaded while scl is held low, so the stretch joins on with no gap
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			stretchLeft <= 8'h00;
		end else if (sclOe) begin
			stretchLeft <= stretchCycles;
		end else if (stretchLeft != 8'h00) begin
			stretchLeft <= stretchLeft - 8'h01;
		end
	end

	// open drain with pull-ups: a released line reads high
	assign sclWire = !(sclOe || stretchLeft != 8'h00);
	assign sdaWire = !(sdaOe || pullSdaLow);
endmodule // i2ctc_bus_model

// ### i2c_timing_config_tb.sv
// self-checking bench of the i2c timing configuration block
`timescale 1ns/1ps
`include "i2ctc_params.svh"
module i2c_timing_config_tb;
	logic                        clock = 1'b0;
	logic                        reset = 1'b1;
	i2ctc_pkg::i2ctc_bus_t       bus = '0;
	i2ctc_pkg::i2ctc_slave_req_t slaveReq = '0;
	logic                        masterRun = 1'b0;
	logic                        oscMode = 1'b0;
	logic                        pixelPresent = 1'b1;
	logic                        pullSdaLow = 1'b0;
	logic [7:0]                  stretchCycles = 8'h00;
	logic [7:0]                  rdata, spareBits;
	logic [1:0]                  oscSelect;
	logic                        sclWire, sdaWire, sclOe, sdaOe, sclFilt, sdaFilt;
	logic                        released, oscActive, sclDrive, sdaDrive;
	int                          errors = 0;
	int                          testsRun = 0;
	int                          cycles = 0;

	i2c_timing_config i_dut (
		.clock(clock), .reset(reset), .bus(bus), .rdata(rdata),
		.sclIn(sclWire), .sdaIn(sdaWire), .sclOut(sclDrive), .sclOe(sclOe),
		.sdaOut(sdaDrive), .sdaOe(sdaOe), .sclFiltered(sclFilt), .sdaFiltered(sdaFilt),
		.masterRun(masterRun), .slaveReq(slaveReq), .slaveReleased(released),
		.internalOscillatorMode(oscMode), .pixelClockPresent(pixelPresent),
		.internalOscillatorSelect(oscSelect), .internalOscillatorActive(oscActive),
		.spareControlBits(spareBits)
	);
	i2ctc_bus_model i_bus (
		.clock(clock), .reset(reset), .sclOe(sclOe), .sdaOe(sdaOe),
		.stretchCycles(stretchCycles), .pullSdaLow(pullSdaLow),
		.sclWire(sclWire), .sdaWire(sdaWire)
	);

	always #50 clock = ~clock;

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic results();
		$display("comparisons %0d mismatches %0d", testsRun, errors);
		if (errors == 0 && testsRun > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// generous ceiling: the longest pass idles at most a few hundred cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			errors++;
			results();
		end
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		testsRun++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic chkReg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
		#1;
		check(rdata, exp);
	endtask

	// cycles sclOe spends at lvl, once it gets there; bounded both ways
	task automatic phaseLen(input logic lvl, output int n);
		n = 0;
		while (sclOe !== lvl && n < 400) begin
			@(posedge clock);
			#1;
			n++;
		end
		n = 0;
		while (sclOe === lvl && n < 400) begin
			@(posedge clock);
			#1;
			n++;
		end
	endtask

	// one low and one high phase, then let the generator run down
	task automatic masterPass(output int lo, output int hi);
		int x;
		@(posedge clock);
		masterRun <= 1'b1;
		#1;
		phaseLen(1'b1, lo);
		phaseLen(1'b0, hi);
		@(posedge clock);
		masterRun <= 1'b0;
		#1;
		phaseLen(1'b1, x);
		phaseLen(1'b0, x);
	endtask

	task automatic sdaLatency(input logic [7:0] cfg, output int n);
		regWrite(`I2CTC_ADDR_FILTER_HOLD, cfg);
		@(posedge clock);
		pullSdaLow <= 1'b1;
		n = 0;
		#1;
		while (sdaFilt === 1'b1 && n < 100) begin
			@(posedge clock);
			#1;
			n++;
		end
		pullSdaLow <= 1'b0;
		while (sdaFilt !== 1'b1 && n < 200) begin
			@(posedge clock);
			#1;
			n++;
		end
	endtask

	task automatic glitch(input int g, output logic seen);
		seen = 1'b0;
		@(posedge clock);
		pullSdaLow <= 1'b1;
		repeat (g) @(posedge clock);
		pullSdaLow <= 1'b0;
		repeat (40) begin
			#1;
			seen |= !sdaFilt;
			@(posedge clock);
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic testDefaults();
		chkReg(`I2CTC_ADDR_FILTER_HOLD, `I2CTC_RST_FILTER_HOLD);
		chkReg(`I2CTC_ADDR_SCL_HIGH, `I2CTC_RST_SCL_HIGH);
		chkReg(`I2CTC_ADDR_SCL_LOW, `I2CTC_RST_SCL_LOW);
		chkReg(`I2CTC_ADDR_SPARE, `I2CTC_RST_SPARE);
		chkReg(`I2CTC_ADDR_CLOCK_SELECT, `I2CTC_RST_CLOCK_SELECT);
		chkReg(8'h15, 8'h00);
		check({6'h00, oscSelect}, 8'h00);
		check({6'h00, sclFilt, sdaFilt}, 8'h03);
	endtask

	task automatic testMaster();
		int lo0, hi0, lo1, hi1, lo2, hi2;
		masterPass(lo0, hi0);
		check(8'(lo0), 8'h41);
		regWrite(`I2CTC_ADDR_SCL_HIGH, 8'h04);
		// low outlasts the filter latency, so the high count starts on a clean line
		regWrite(`I2CTC_ADDR_SCL_LOW, 8'h0c);
		masterPass(lo1, hi1);
		check(8'(lo1), 8'h06);
		check(8'(hi0 - hi1), 8'h3f);
		stretchCycles <= 8'h05;
		masterPass(lo2, hi2);
		stretchCycles <= 8'h00;
		check(8'(hi2 - hi1), 8'h05);
	endtask

	task automatic testSlave();
		int n;
		regWrite(`I2CTC_ADDR_SCL_LOW, 8'h06);
		for (int b = 0; b < 2; b++) begin
			@(posedge clock);
			slaveReq.slaveStretch <= 1'b1;
			@(posedge clock);
			#1;
			check(8'(sclOe), 8'h01);
			@(posedge clock);
			slaveReq.slaveDataValid <= 1'b1;
			slaveReq.slaveSdaBit <= b[0];
			@(posedge clock);
			slaveReq.slaveDataValid <= 1'b0;
			slaveReq.slaveStretch <= 1'b0;
			#1;
			check(8'(sdaOe), 8'(!b[0]));
			check({6'h00, sclDrive, sdaDrive}, 8'h00);
			phaseLen(1'b1, n);
			check(8'(n), 8'h03);
			check(8'(released), 8'h01);
			@(posedge clock);
			#1;
			check({6'h00, released, sclOe}, 8'h00);
		end
	endtask

	// limit is one cycle at depth 2 and two at depth 15
	task automatic testFilter();
		int l12, l1f, l72;
		logic s;
		sdaLatency(8'h12, l12);
		glitch(1, s);
		check(8'(s), 8'h00);
		glitch(2, s);
		check(8'(s), 8'h01);
		sdaLatency(8'h1f, l1f);
		glitch(2, s);
		check(8'(s), 8'h00);
		glitch(3, s);
		check(8'(s), 8'h01);
		sdaLatency(8'h72, l72);
		// falling and rising edge both counted
		check(8'(l1f - l12), 8'h02);
		check(8'(l72 - l12), 8'h06);
	endtask

	task automatic testRegsAndClock();
		regWrite(`I2CTC_ADDR_FILTER_HOLD, 8'hff);
		chkReg(`I2CTC_ADDR_FILTER_HOLD, 8'hff);
		regWrite(`I2CTC_ADDR_SPARE, 8'ha5);
		chkReg(`I2CTC_ADDR_SPARE, 8'ha5);
		check(spareBits, 8'ha5);
		regWrite(8'h15, 8'h5a);
		chkReg(8'h15, 8'h00);
		for (int c = 0; c < 4; c++) begin
			regWrite(`I2CTC_ADDR_CLOCK_SELECT, 8'hf9 | 8'(c << 1));
			chkReg(`I2CTC_ADDR_CLOCK_SELECT, 8'h19 | 8'(c << 1));
			check({6'h00, oscSelect}, 8'(c));
		end
		// two sync stages plus the output register
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			oscMode <= i[1];
			pixelPresent <= i[0];
			repeat (4) @(posedge clock);
			#1;
			check(8'(oscActive), 8'(i[1] | !i[0]));
		end
	endtask

	initial begin
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		testDefaults();
		testMaster();
		testSlave();
		testFilter();
		testRegsAndClock();
		results();
	end
endmodule // i2c_timing_config_tb
